// file: wdt_pkg.sv
// Purpose: Shared constants and types for the windowed watchdog timer.
// Assumes: Option byte is a static input; one clock domain.
// Notes:   Low-speed oscillator ticks arrive as a pulse on the system clock.
`default_nettype none
package wdt_pkg;
  localparam int           CNT_W           = 17;
  localparam logic [7:0]   KICK_KEY        = 8'hac;
  localparam logic [7:0]   READ_RUN_VAL    = 8'h9a;
  localparam logic [7:0]   READ_STOP_VAL   = 8'h1a;
  localparam int           OPT_IRQ_BIT     = 7;
  localparam int           OPT_WIN_HI_BIT  = 6;
  localparam int           OPT_WIN_LO_BIT  = 5;
  localparam int           OPT_EN_BIT      = 4;
  localparam int           OPT_OVF_MSB     = 3;
  localparam int           OPT_OVF_LSB     = 1;
  localparam int           OPT_STBY_BIT    = 0;
  localparam int           RESET_CAUSE_REGISTER_WDT_BIT    = 4;
  localparam logic [3:0]   KICK_ADDR       = 4'h1;
  localparam logic [3:0]   RESET_CAUSE_REGISTER_ADDR       = 4'h2;
  localparam int           SYNC_TICKS      = 2;
  localparam logic [7:0]   RESET_CAUSE_REGISTER_RST        = 8'h00;

  typedef struct packed {
    logic       irq_en;
    logic       win_hi;
    logic       win_lo;
    logic       cnt_en;
    logic [2:0] ovf_code;
    logic       stby_run;
  } opt_s;

  typedef enum logic [1:0] {
    ERR_NONE, ERR_KEY, ERR_BITOP, ERR_WINDOW
  } err_e;
endpackage : wdt_pkg
`default_nettype wire

// file: wdt_limits.sv
// Purpose: Decodes the overflow code into overflow, window and interval points.
// Assumes: Count is in oscillator ticks.
// Notes:   Pure combinational.
`default_nettype none
module wdt_limits (
  input  wire logic [2:0]  ovf_code_in,
  output logic      [16:0] ovf_last_out,
  output logic      [16:0] open_at_out,
  output logic      [16:0] irq_at_out
);
  logic [4:0]  shift_amt;
  logic [17:0] period;
  logic [16:0] quarter;

  assign shift_amt = (ovf_code_in == 3'h0) ? 5'h06 :
                     (ovf_code_in == 3'h1) ? 5'h07 :
                     (ovf_code_in == 3'h2) ? 5'h08 :
                     (ovf_code_in == 3'h3) ? 5'h09 :
                     (ovf_code_in == 3'h4) ? 5'h0b :
                     (ovf_code_in == 3'h5) ? 5'h0d :
                     (ovf_code_in == 3'h6) ? 5'h0e : 5'h10;
  assign period       = 18'h00001 << shift_amt;
  assign quarter      = {1'b0, period[17:2]};
  assign ovf_last_out = period[16:0] - 17'h00001;
  assign open_at_out  = quarter;
  // Interval point is three quarters of the period, half tick rounds up.
  assign irq_at_out   = period[16:0] - quarter;
endmodule : wdt_limits
`default_nettype wire

// file: windowed_watchdog.sv
// Purpose: Windowed watchdog with key kick, window check and interval event.
// Assumes: osc_tick_in pulses once per low-speed oscillator cycle.
// Notes:   wdt_reset_out is a one-cycle request to the reset controller.
//
// Implementation choices: the strobed register port and the address map.
`default_nettype none
module windowed_watchdog #(
  parameter int CNT_W = wdt_pkg::CNT_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic              arst_n_in,
  input  wire wdt_pkg::opt_s     option_in,
  input  wire logic              osc_tick_in,
  input  wire logic              sleep_in,
  input  wire logic [3:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              bitop_in,
  input  wire logic              reset_cause_register_clr_in,
  output logic      [7:0]        rdata_out,
  output logic                   wdt_reset_out,
  output logic                   interval_interrupt_out,
  output logic                   watchdog_reset_flag_out
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             first_done_reg;
  logic             pend_clr_reg;
  logic [1:0]       clr_ticks_reg;
  logic             irq_done_reg;
  logic             sleep_d_reg;
  logic [7:0]       rdata_reg;
  logic             rst_reg;
  logic             irq_reg;
  logic [7:0]       reset_cause_register_reg;
  logic [16:0]      ovf_last;
  logic [16:0]      open_at;
  logic [16:0]      irq_at;
  logic [CNT_W-1:0] cnt17;

  wdt_limits u_limits (
    .ovf_code_in  (option_in.ovf_code),
    .ovf_last_out (ovf_last),
    .open_at_out  (open_at),
    .irq_at_out   (irq_at)
  );

  assign cnt17 = count_reg;

  wire kick_sel   = wr_in && (addr_in == wdt_pkg::KICK_ADDR);
  wire reset_cause_register_rd    = rd_in && (addr_in == wdt_pkg::RESET_CAUSE_REGISTER_ADDR);
  wire kick_rd    = rd_in && (addr_in == wdt_pkg::KICK_ADDR);
  // Halting in sleep only when standby run is off.
  wire halted     = sleep_in && !option_in.stby_run;
  wire wake       = sleep_d_reg && !sleep_in && !option_in.stby_run;
  wire running    = option_in.cnt_en && !halted;
  wire full_open  = !option_in.stby_run || option_in.win_lo;
  wire win_closed = !full_open && (cnt17 < open_at);
  wire err_bitop  = kick_sel && bitop_in;
  wire err_key    = kick_sel && !bitop_in && (wdata_in != wdt_pkg::KICK_KEY);
  wire err_win    = kick_sel && first_done_reg && win_closed;
  wire good_kick  = kick_sel && !err_bitop && !err_key && !err_win;
  wire overflow   = running && osc_tick_in && !pend_clr_reg
                    && (cnt17 == ovf_last);
  wire fire_rst   = option_in.cnt_en
                    && (err_bitop || err_key || err_win || overflow);
  wire clr_now    = pend_clr_reg && osc_tick_in
                    && (clr_ticks_reg == 2'(wdt_pkg::SYNC_TICKS - 1));
  wire irq_hit    = option_in.irq_en && running && !irq_done_reg
                    && (cnt17 == irq_at);

  always_comb begin
    count_next = count_reg;
    if (wake || clr_now) begin
      count_next = '0;
    end else if (running && osc_tick_in && !overflow) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // Clear request is retimed onto the oscillator tick, as the real
  // counter lives in the slow domain.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_clr_reg  <= 1'b0;
      clr_ticks_reg <= 2'h0;
    end else if (good_kick) begin
      pend_clr_reg  <= 1'b1;
      clr_ticks_reg <= 2'h0;
    end else if (clr_now) begin
      pend_clr_reg  <= 1'b0;
    end else if (pend_clr_reg && osc_tick_in) begin
      clr_ticks_reg <= clr_ticks_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_done_reg <= 1'b0;
    end else if (kick_sel) begin
      first_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_done_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      irq_reg <= irq_hit;
      if (clr_now || wake) begin
        irq_done_reg <= 1'b0;
      end else if (irq_hit) begin
        irq_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sleep_d_reg <= 1'b0;
      rst_reg     <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_in;
      rst_reg     <= fire_rst;
    end
  end

  // Set wins over a software clear of the flag.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_cause_register_reg <= wdt_pkg::RESET_CAUSE_REGISTER_RST;
    end else if (fire_rst) begin
      reset_cause_register_reg[wdt_pkg::RESET_CAUSE_REGISTER_WDT_BIT] <= 1'b1;
    end else if (reset_cause_register_clr_in) begin
      reset_cause_register_reg[wdt_pkg::RESET_CAUSE_REGISTER_WDT_BIT] <= 1'b0;
    end
  end

  wire [7:0] kick_rval = option_in.cnt_en ? wdt_pkg::READ_RUN_VAL
                                          : wdt_pkg::READ_STOP_VAL;
  wire [7:0] rd_mux    = kick_rd ? kick_rval :
                         reset_cause_register_rd ? reset_cause_register_reg  : 8'h00;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= (rd_in) ? rd_mux : 8'h00;
    end
  end

  assign rdata_out               = rdata_reg;
  assign wdt_reset_out           = rst_reg;
  assign interval_interrupt_out  = irq_reg;
  assign watchdog_reset_flag_out = reset_cause_register_reg[wdt_pkg::RESET_CAUSE_REGISTER_WDT_BIT];

  property p_key_err;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (kick_sel && !bitop_in && wdata_in != wdt_pkg::KICK_KEY
       && option_in.cnt_en) |=> wdt_reset_out;
  endproperty
  a_key_err: assert property (p_key_err) else $error("bad key no reset");

  property p_bitop;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (kick_sel && bitop_in && option_in.cnt_en) |=> wdt_reset_out;
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit op no reset");

  property p_window;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (kick_sel && first_done_reg && win_closed && option_in.cnt_en)
      |=> wdt_reset_out;
  endproperty
  a_window: assert property (p_window) else $error("closed kick no reset");

  property p_first;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (kick_sel && !first_done_reg && !bitop_in
       && wdata_in == wdt_pkg::KICK_KEY) |=> !wdt_reset_out;
  endproperty
  a_first: assert property (p_first) else $error("first kick refused");

  property p_flag;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      wdt_reset_out |-> watchdog_reset_flag_out;
  endproperty
  a_flag: assert property (p_flag) else $error("reset flag not set");

  property p_stopped;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (!option_in.cnt_en && !wake && !clr_now) |=> $stable(count_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count while off");

  property p_sleep;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (halted && !clr_now && !wake) |=> $stable(count_reg);
  endproperty
  a_sleep: assert property (p_sleep) else $error("count in sleep");

  property p_wake;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      wake |=> (count_reg == '0);
  endproperty
  a_wake: assert property (p_wake) else $error("no clear on wake");

  property p_irq_once;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      interval_interrupt_out |=> !interval_interrupt_out;
  endproperty
  a_irq_once: assert property (p_irq_once) else $error("irq repeated");

  property p_rd;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      kick_rd |=> (rdata_out == (option_in.cnt_en ? wdt_pkg::READ_RUN_VAL
                                                  : wdt_pkg::READ_STOP_VAL));
  endproperty
  a_rd: assert property (p_rd) else $error("kick read value wrong");

  // These pair each event with its output and each quiet case with a low
  // output, so a stray or a missing pulse is caught at its cause.
  property p_overflow;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (running && osc_tick_in && !pend_clr_reg && count_reg == ovf_last)
      |=> wdt_reset_out;
  endproperty
  a_overflow: assert property (p_overflow) else $error("no ovf reset");

  property p_lag;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      pend_clr_reg |-> (clr_ticks_reg < 2'(wdt_pkg::SYNC_TICKS));
  endproperty
  a_lag: assert property (p_lag) else $error("clear lag too long");

  property p_irq;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (option_in.irq_en && running && !irq_done_reg && count_reg == irq_at)
      |=> interval_interrupt_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interval irq missed");

  property p_no_irq;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      !option_in.irq_en |=> !interval_interrupt_out;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while off");

  property p_open;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (kick_sel && !option_in.stby_run && !bitop_in && !overflow
       && wdata_in == wdt_pkg::KICK_KEY) |=> !wdt_reset_out;
  endproperty
  a_open: assert property (p_open) else $error("open kick refused");

  property p_quiet;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      !option_in.cnt_en |=> !wdt_reset_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset while off");

  property p_count_up;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      (running && osc_tick_in && !overflow && !clr_now && !wake)
      |=> (count_reg == $past(count_reg) + 1'b1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("no count");

  c_first: cover property (@(posedge sys_clk_in) kick_sel && !first_done_reg);
  c_kick:  cover property (@(posedge sys_clk_in) good_kick && first_done_reg);
  c_ovf:   cover property (@(posedge sys_clk_in) overflow);
  c_irq:   cover property (@(posedge sys_clk_in) interval_interrupt_out);
  c_wake:  cover property (@(posedge sys_clk_in) wake);
endmodule : windowed_watchdog
`default_nettype wire

// file: test_windowed_watchdog.sv
// Purpose: Self-checking bench for windowed_watchdog.
// Assumes: Oscillator tick pulses every fourth system clock.
// Notes:   Every scenario starts from a fresh bench reset.
`default_nettype none
module test_windowed_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk = 1'b0;
  logic          rst_n;
  wdt_pkg::opt_s opt;
  logic          tick;
  logic          sleep;
  logic [3:0]    addr;
  logic [7:0]    wdata;
  logic          wr;
  logic          rd;
  logic          bitop;
  logic          clr;
  logic [7:0]    rdata;
  logic          wrst;
  logic          irq;
  logic          flag;
  logic [1:0]    ph;
  int            n;
  int            rsts;
  int            rst_at;
  int            irqs;
  int            irq_at;
  int            b;
  int            bad_count = 0;
  int            check_count = 0;
  int            per [6] = '{64, 128, 256, 512, 2048, 8192};

  always #12.5 clk = ~clk;

  windowed_watchdog uut (
    .sys_clk_in              (clk),
    .arst_n_in               (rst_n),
    .option_in               (opt),
    .osc_tick_in             (tick),
    .sleep_in                (sleep),
    .addr_in                 (addr),
    .wdata_in                (wdata),
    .wr_in                   (wr),
    .rd_in                   (rd),
    .bitop_in                (bitop),
    .reset_cause_register_clr_in             (clr),
    .rdata_out               (rdata),
    .wdt_reset_out           (wrst),
    .interval_interrupt_out  (irq),
    .watchdog_reset_flag_out (flag)
  );

  // Makes the ticks and notes the tick count at the first reset and event.
  always @(posedge clk) begin
    if (!rst_n) begin
      ph <= 2'h0;
      tick <= 1'b0;
      n <= 0;
      rsts <= 0;
      irqs <= 0;
    end else begin
      ph <= ph + 2'h1;
      tick <= (ph == 2'h3);
      if (ph == 2'h3) n <= n + 1;
      if (wrst === 1'b1) rsts <= rsts + 1;
      if (wrst === 1'b1 && rsts == 0) rst_at <= n;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (irq === 1'b1 && irqs == 0) irq_at <= n;
    end
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic restart(input logic [7:0] v);
    @(posedge clk);
    rst_n <= 1'b0;
    opt   <= wdt_pkg::opt_s'(v);
    sleep <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask : restart

  task automatic run(input int c);
    repeat (c) @(posedge clk);
  endtask : run

  task automatic kick(input logic [7:0] d, input logic bop);
    @(posedge clk);
    addr  <= wdt_pkg::KICK_ADDR;
    wdata <= d;
    bitop <= bop;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    bitop <= 1'b0;
  endtask : kick

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata === exp, "read data");
  endtask : rd_chk

  task automatic summarize;
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    rst_n = 1'b0;
    opt = '0;
    tick = 1'b0;
    sleep = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bitop = 1'b0;
    clr = 1'b0;
    @(posedge clk);
    for (int c = 0; c < 6; c++) begin
      restart(8'hd1 | {4'h0, c[2:0], 1'b0});
      if (c == 0) rd_chk(wdt_pkg::KICK_ADDR, wdt_pkg::READ_RUN_VAL);
      run(per[c] * 4 + 12);
      chk(rsts > 0 && rst_at == per[c], "overflow time");
      chk(irqs == 1 && irq_at == per[c] * 3 / 4, "interval");
      chk(flag === 1'b1, "reset flag");
      rd_chk(wdt_pkg::RESET_CAUSE_REGISTER_ADDR, 8'h01 << wdt_pkg::RESET_CAUSE_REGISTER_WDT_BIT);
    end
    restart(8'hc1);
    rd_chk(wdt_pkg::KICK_ADDR, wdt_pkg::READ_STOP_VAL);
    kick(8'h55, 1'b0);
    run(300);
    chk(rsts == 0 && irqs == 0, "stopped counter");
    restart(8'h51);
    kick(8'h55, 1'b0);
    run(4);
    chk(rsts > 0 && flag === 1'b1, "bad key");
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    rd_chk(wdt_pkg::RESET_CAUSE_REGISTER_ADDR, 8'h00);
    chk(flag === 1'b0, "flag clear");
    restart(8'h51);
    kick(wdt_pkg::KICK_KEY, 1'b1);
    run(4);
    chk(rsts > 0, "bit operation");
    restart(8'h51);
    kick(wdt_pkg::KICK_KEY, 1'b0);
    run(4);
    chk(rsts == 0, "first kick");
    kick(wdt_pkg::KICK_KEY, 1'b0);
    run(4);
    chk(rsts > 0, "closed window");
    restart(8'h50);
    kick(wdt_pkg::KICK_KEY, 1'b0);
    kick(wdt_pkg::KICK_KEY, 1'b0);
    run(4);
    chk(rsts == 0, "standby off window");
    restart(8'h71);
    run(160);
    kick(wdt_pkg::KICK_KEY, 1'b0);
    #1 b = n;
    kick(wdt_pkg::KICK_KEY, 1'b0);
    run(300);
    chk(rsts > 0 && rst_at >= b + 64 && rst_at <= b + 67, "kick");
    restart(8'h51);
    sleep <= 1'b1;
    run(300);
    chk(rsts > 0 && irqs == 0, "standby run");
    restart(8'h50);
    run(100);
    sleep <= 1'b1;
    run(400);
    chk(rsts == 0, "sleep halt");
    sleep <= 1'b0;
    #1 b = n;
    run(300);
    chk(rsts > 0 && rst_at >= b + 64 && rst_at <= b + 67, "wake");
    summarize();
  end
endmodule : test_windowed_watchdog
`default_nettype wire
